//--- pkg/sps_defines.svh
// Register map, field positions, reset values and codes of the serial port status block.
// Summary of operation
// (R1) Built-in port error flag, status bit 04, sets on any communication error there.
// (R2) Built-in transmit-allowed flag, bit 05, shown only in host link or plain mode.
// (R3) Built-in reception-finished flag, bit 06, shown only in plain serial mode.
// (R4) Built-in receive overflow flag, bit 07, shown only in host link or plain mode.
// (R5) Peripheral result code, bits 08 to 11: 0 normal, 1 parity, 2 framing, 3 overrun.
// (R6) Peripheral port error flag, bit 12, sets on any peripheral communication error.
// (R7) Peripheral transmit-allowed flag, bit 13, shown only in host link or plain mode.
// (R8) Peripheral reception-finished flag, bit 14, shown only in plain serial mode.
// (R9) Peripheral receive overflow flag, bit 15, shown only in host link or plain mode.
// (R10) Built-in reception count, four BCD digits in one word, plain mode only.
// (R11) Peripheral reception count, four BCD digits in its own word, plain mode only.
// (R12) Built-in result code, bits 00 to 03, same encoding 0 to 3.
// (R13) Error code and error flag change together; nonzero code never shows with flag clear.
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// ==========================================================================
// Register indices; byte address is four times the index.
`define SPS_IDX_CTRL        4'h0
`define SPS_IDX_CLEAR       4'h1
`define SPS_IDX_STATUS      4'h8
`define SPS_IDX_BI_COUNT    4'h9
`define SPS_IDX_PP_COUNT    4'hA

// ==========================================================================
// Status word fields.
`define SPS_ST_BI_CODE_LSB  0
`define SPS_ST_BI_ERR       4
`define SPS_ST_BI_TXOK      5
`define SPS_ST_BI_RXDONE    6
`define SPS_ST_BI_OVF       7
`define SPS_ST_PP_CODE_LSB  8
`define SPS_ST_PP_ERR       12
`define SPS_ST_PP_TXOK      13
`define SPS_ST_PP_RXDONE    14
`define SPS_ST_PP_OVF       15

// ==========================================================================
// Control word: mode of each port. Clear word: one write-one strobe per item.
`define SPS_CTRL_BI_MODE_LSB 0
`define SPS_CTRL_PP_MODE_LSB 2
`define SPS_CTRL_RESET      4'h0
`define SPS_CLR_PP_LSB      4

// ==========================================================================
// Reset values.
`define SPS_COUNT_RESET     16'h0000
`define SPS_CODE_RESET      2'h0

// ==========================================================================
// Bus answers.
`define SPS_RESP_OKAY       2'h0
`define SPS_RESP_SLVERR     2'h2
`define SPS_RESP_DECERR     2'h3

`endif

//--- pkg/sps_pkg.sv
// Types shared by the serial port status block.
package sps_pkg;

  // ==========================================================================
  // Port protocol modes.
  typedef enum logic [1:0] {
    SPS_MODE_HOST_LINK = 2'h0,
    SPS_MODE_RS232C    = 2'h1,
    SPS_MODE_OTHER     = 2'h2,
    SPS_MODE_IDLE      = 2'h3
  } sps_mode_t;

  // Result codes.
  typedef enum logic [1:0] {
    SPS_ERR_NONE    = 2'h0,
    SPS_ERR_PARITY  = 2'h1,
    SPS_ERR_FRAMING = 2'h2,
    SPS_ERR_OVERRUN = 2'h3
  } sps_err_t;

  // Events and levels from one port's serial logic, same clock.
  typedef struct packed {
    logic     err_pulse;
    sps_err_t err_code;
    logic     tx_allowed;
    logic     rx_done_pulse;
    logic     rx_ovf_pulse;
    logic     rx_byte_pulse;
  } sps_port_evt_t;

  // Software clear strobes for one port.
  typedef struct packed {
    logic clr_count;
    logic clr_ovf;
    logic clr_done;
    logic clr_err;
  } sps_port_clr_t;

  // One port's byte of the status word.
  typedef struct packed {
    logic     ovf;
    logic     rx_done;
    logic     tx_ok;
    logic     err;
    logic [1:0] code_hi;
    sps_err_t code;
  } sps_port_stat_t;

  // Bus state machines.
  typedef enum logic [1:0] {
    SPS_WR_COLLECT = 2'h0,
    SPS_WR_RESP    = 2'h1
  } sps_wr_state_t;

  typedef enum logic {
    SPS_RD_IDLE = 1'b0,
    SPS_RD_DATA = 1'b1
  } sps_rd_state_t;

endpackage

//--- hw/sps_bcd_counter.sv
// Four-digit BCD reception counter.
`timescale 1ns/10ps
`include "sps_defines.svh"

module sps_bcd_counter (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        count_en,
  input  wire logic        clear,
  output logic [15:0]      count
);

  // Carries ripple digit by digit; 9999 wraps to 0000.
  function automatic logic [15:0] bcd_inc(input logic [15:0] v);
    logic [15:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (v[i*4 +: 4] == 4'h9) begin
          r[i*4 +: 4] = 4'h0;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction

  // A byte arriving with a clear is counted from zero, so it is not lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= `SPS_COUNT_RESET;
    end else if (clear && count_en) begin
      count <= bcd_inc(`SPS_COUNT_RESET);
    end else if (clear) begin
      count <= `SPS_COUNT_RESET;
    end else if (count_en) begin
      count <= bcd_inc(count);
    end
  end

endmodule // sps_bcd_counter

//--- hw/sps_port_track.sv
// Sticky status flags and result code of one serial port.
`timescale 1ns/10ps
`include "sps_defines.svh"

module sps_port_track (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire sps_pkg::sps_port_evt_t evt,
  input  wire sps_pkg::sps_mode_t     mode,
  input  wire sps_pkg::sps_port_clr_t clr,
  output sps_pkg::sps_port_stat_t     stat
);

  logic             err_flag;
  sps_pkg::sps_err_t err_code;
  logic             done_flag;
  logic             ovf_flag;
  logic             link_or_plain;
  logic             plain;

  assign plain         = (mode == sps_pkg::SPS_MODE_RS232C);
  assign link_or_plain = plain || (mode == sps_pkg::SPS_MODE_HOST_LINK);

  // Code and flag share one process so they can never disagree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_flag <= 1'b0;
      err_code <= sps_pkg::SPS_ERR_NONE;
    end else if (evt.err_pulse) begin
      err_flag <= 1'b1; // R1 R6 R13
      err_code <= evt.err_code; // R5 R12
    end else if (clr.clr_err) begin
      err_flag <= 1'b0; // R13
      err_code <= sps_pkg::SPS_ERR_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag <= 1'b0;
    end else if (evt.rx_done_pulse && plain) begin
      done_flag <= 1'b1; // R3 R8
    end else if (clr.clr_done) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag <= 1'b0;
    end else if (evt.rx_ovf_pulse && link_or_plain) begin
      ovf_flag <= 1'b1; // R4 R9
    end else if (clr.clr_ovf) begin
      ovf_flag <= 1'b0;
    end
  end

  // Flags outside their valid modes read as zero rather than stale history.
  always_comb begin
    stat         = '0;
    stat.code    = err_code;
    stat.err     = err_flag;
    stat.tx_ok   = evt.tx_allowed && link_or_plain; // R2 R7
    stat.rx_done = done_flag && plain; // R3 R8
    stat.ovf     = ovf_flag && link_or_plain; // R4 R9
  end

endmodule // sps_port_track

//--- hw/sps_status_regs.sv
// AXI4-Lite register file for the serial port status and reception counters.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "sps_defines.svh"

module sps_status_regs #(
  parameter int AW = 6
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire sps_pkg::sps_port_evt_t bi_evt,
  input  wire sps_pkg::sps_port_evt_t pp_evt,
  input  wire logic [AW-1:0]          s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [AW-1:0]          s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output sps_pkg::sps_mode_t          bi_mode,
  output sps_pkg::sps_mode_t          pp_mode
);

  // ==========================================================================
  // Address decoding.

  // Word index from a byte address; address bits outside the index field are ignored, so such offsets alias.
  function automatic logic [3:0] word_index(input logic [AW-1:0] a);
    return a[5:2];
  endfunction

  function automatic logic is_mapped(input logic [AW-1:0] a);
    logic [3:0] i;
    i = word_index(a);
    return (i == `SPS_IDX_CTRL) || (i == `SPS_IDX_CLEAR) || (i == `SPS_IDX_STATUS) ||
           (i == `SPS_IDX_BI_COUNT) || (i == `SPS_IDX_PP_COUNT);
  endfunction

  function automatic logic is_writable(input logic [AW-1:0] a);
    logic [3:0] i;
    i = word_index(a);
    return (i == `SPS_IDX_CTRL) || (i == `SPS_IDX_CLEAR);
  endfunction

  // ==========================================================================
  // Write channel.

  sps_pkg::sps_wr_state_t wr_state;
  logic                   aw_held;
  logic                   w_held;
  logic [AW-1:0]          aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;
  logic [3:0]             ctrl;
  sps_pkg::sps_port_clr_t bi_clr;
  sps_pkg::sps_port_clr_t pp_clr;

  // Address and data are taken in either order and held until both are in.
  assign s_axi_awready = (wr_state == sps_pkg::SPS_WR_COLLECT) && !aw_held;
  assign s_axi_wready  = (wr_state == sps_pkg::SPS_WR_COLLECT) && !w_held;
  assign wr_fire       = (wr_state == sps_pkg::SPS_WR_COLLECT) && aw_held && w_held;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state     <= sps_pkg::SPS_WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SPS_RESP_OKAY;
    end else begin
      unique case (wr_state)
        sps_pkg::SPS_WR_COLLECT: begin
          if (wr_fire) begin
            wr_state     <= sps_pkg::SPS_WR_RESP;
            s_axi_bvalid <= 1'b1;
            if (!is_mapped(aw_addr)) begin
              s_axi_bresp <= `SPS_RESP_DECERR;
            end else if (!is_writable(aw_addr)) begin
              s_axi_bresp <= `SPS_RESP_SLVERR;
            end else begin
              s_axi_bresp <= `SPS_RESP_OKAY;
            end
          end
        end
        sps_pkg::SPS_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= sps_pkg::SPS_WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state     <= sps_pkg::SPS_WR_COLLECT;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Mode control; only byte lane 0 carries it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `SPS_CTRL_RESET;
    end else if (wr_fire && w_strb[0] && (word_index(aw_addr) == `SPS_IDX_CTRL)) begin
      ctrl <= w_data[3:0];
    end
  end

  assign bi_mode = sps_pkg::sps_mode_t'(ctrl[`SPS_CTRL_BI_MODE_LSB +: 2]);
  assign pp_mode = sps_pkg::sps_mode_t'(ctrl[`SPS_CTRL_PP_MODE_LSB +: 2]);

  // Write-one-to-clear strobes last one cycle; a same-cycle event still sets.
  always_comb begin
    bi_clr = '0;
    pp_clr = '0;
    if (wr_fire && w_strb[0] && (word_index(aw_addr) == `SPS_IDX_CLEAR)) begin
      bi_clr = sps_pkg::sps_port_clr_t'(w_data[3:0]);
      pp_clr = sps_pkg::sps_port_clr_t'(w_data[`SPS_CLR_PP_LSB +: 4]);
    end
  end

  // ==========================================================================
  // Port trackers and counters.

  sps_pkg::sps_port_stat_t bi_stat;
  sps_pkg::sps_port_stat_t pp_stat;
  logic [15:0]             bi_count;
  logic [15:0]             pp_count;
  logic [15:0]             status_word;

  sps_port_track u_bi_track (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (bi_evt),
    .mode    (bi_mode),
    .clr     (bi_clr),
    .stat    (bi_stat)
  );

  sps_port_track u_pp_track (
    .aclk    (aclk),
    .aresetn (aresetn),
    .evt     (pp_evt),
    .mode    (pp_mode),
    .clr     (pp_clr),
    .stat    (pp_stat)
  );

  // Counting only in plain serial mode; other modes freeze the count.
  sps_bcd_counter u_bi_count (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .count_en (bi_evt.rx_byte_pulse && (bi_mode == sps_pkg::SPS_MODE_RS232C)), // R10
    .clear    (bi_clr.clr_count),
    .count    (bi_count)
  );

  sps_bcd_counter u_pp_count (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .count_en (pp_evt.rx_byte_pulse && (pp_mode == sps_pkg::SPS_MODE_RS232C)), // R11
    .clear    (pp_clr.clr_count),
    .count    (pp_count)
  );

  always_comb begin
    status_word                               = 16'h0000;
    status_word[`SPS_ST_BI_CODE_LSB +: 2]     = bi_stat.code; // R12
    status_word[`SPS_ST_BI_ERR]               = bi_stat.err; // R1
    status_word[`SPS_ST_BI_TXOK]              = bi_stat.tx_ok; // R2
    status_word[`SPS_ST_BI_RXDONE]            = bi_stat.rx_done; // R3
    status_word[`SPS_ST_BI_OVF]               = bi_stat.ovf; // R4
    status_word[`SPS_ST_PP_CODE_LSB +: 2]     = pp_stat.code; // R5
    status_word[`SPS_ST_PP_ERR]               = pp_stat.err; // R6
    status_word[`SPS_ST_PP_TXOK]              = pp_stat.tx_ok; // R7
    status_word[`SPS_ST_PP_RXDONE]            = pp_stat.rx_done; // R8
    status_word[`SPS_ST_PP_OVF]               = pp_stat.ovf; // R9
  end

  // ==========================================================================
  // Read channel.

  sps_pkg::sps_rd_state_t rd_state;

  // Counts outside plain mode read as zero, since they are not meaningful there.
  function automatic logic [31:0] read_word(input logic [AW-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (word_index(a))
      `SPS_IDX_CTRL:     r[3:0]  = ctrl;
      `SPS_IDX_STATUS:   r[15:0] = status_word;
      `SPS_IDX_BI_COUNT: r[15:0] = (bi_mode == sps_pkg::SPS_MODE_RS232C) ? bi_count : 16'h0000;
      `SPS_IDX_PP_COUNT: r[15:0] = (pp_mode == sps_pkg::SPS_MODE_RS232C) ? pp_count : 16'h0000;
      default:           r       = 32'h0000_0000;
    endcase
    return r;
  endfunction

  assign s_axi_arready = (rd_state == sps_pkg::SPS_RD_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state     <= sps_pkg::SPS_RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SPS_RESP_OKAY;
    end else begin
      unique case (rd_state)
        sps_pkg::SPS_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state     <= sps_pkg::SPS_RD_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= read_word(s_axi_araddr); // R10 R11
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? `SPS_RESP_OKAY : `SPS_RESP_DECERR;
          end
        end
        sps_pkg::SPS_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state     <= sps_pkg::SPS_RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
      endcase
    end
  end

endmodule // sps_status_regs

//--- verification/sps_serial_peer.sv
// Behavioural far-end serial equipment that raises one port's event pulses.
`timescale 1ns/10ps

module sps_serial_peer (
  input  wire logic                   aclk,
  input  wire logic                   fire,
  input  wire sps_pkg::sps_port_evt_t want,
  output sps_pkg::sps_port_evt_t      evt
);
  // ==========================================================================
  // Events
  // Pulses last one cycle; the transmit-allowed level stays as last set, as on a real line.
  // The level is kept apart so that each edge writes the event word exactly once.
  logic tx_level = 1'b0;
  always @(posedge aclk) begin
    if (fire) begin
      evt      <= want;
      tx_level <= want.tx_allowed;
    end else begin
      evt      <= sps_pkg::sps_port_evt_t'({3'h0, tx_level, 3'h0});
    end
  end
endmodule // sps_serial_peer

//--- verification/sps_status_regs_chk.sv
// Bus and status-word assertions for the serial port status block.
`timescale 1ns/10ps

module sps_status_regs_chk #(
  parameter int AW = 6
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [AW-1:0]      s_axi_araddr,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic [1:0]         s_axi_rresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire sps_pkg::sps_mode_t bi_mode,
  input wire sps_pkg::sps_mode_t pp_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // Read in flight
  // An answer is judged by the modes in force when it was asked for.
  logic [5:0]         ra;
  sps_pkg::sps_mode_t rbm;
  sps_pkg::sps_mode_t rpm;
  logic               b_plain, b_link, p_plain, p_link;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ra  <= s_axi_araddr[5:0];
      rbm <= bi_mode;
      rpm <= pp_mode;
    end
  end
  always_comb begin
    b_plain = rbm == sps_pkg::SPS_MODE_RS232C;
    b_link  = b_plain || rbm == sps_pkg::SPS_MODE_HOST_LINK;
    p_plain = rpm == sps_pkg::SPS_MODE_RS232C;
    p_link  = p_plain || rpm == sps_pkg::SPS_MODE_HOST_LINK;
  end

  sequence s_ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_wr_both; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_stat_ans; s_axi_rvalid && ra == 6'h20; endsequence

  // ==========================================================================
  // Assertions
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped or changed");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped or changed");
  a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_refuses: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during answer");
  a_bi_code_pair: assert property (s_stat_ans |->
    s_axi_rdata[3:2] == 2'h0 && (s_axi_rdata[1:0] == 2'h0 || s_axi_rdata[4]))
    else $error("built-in code without error flag");
  a_pp_code_pair: assert property (s_stat_ans |->
    s_axi_rdata[11:10] == 2'h0 && (s_axi_rdata[9:8] == 2'h0 || s_axi_rdata[12]))
    else $error("peripheral code without error flag");
  a_bi_mode_mask: assert property (s_stat_ans |->
    (b_plain || !s_axi_rdata[6]) && (b_link || s_axi_rdata[7:5] == 3'h0))
    else $error("built-in flag shown outside its mode");
  a_pp_mode_mask: assert property (s_stat_ans |->
    (p_plain || !s_axi_rdata[14]) && (p_link || s_axi_rdata[15:13] == 3'h0))
    else $error("peripheral flag shown outside its mode");
  a_count_mask: assert property (s_axi_rvalid &&
    (ra == 6'h24 && !b_plain || ra == 6'h28 && !p_plain) |-> s_axi_rdata == 32'h0)
    else $error("count shown outside plain mode");
endmodule // sps_status_regs_chk

bind sps_status_regs sps_status_regs_chk #(.AW(AW)) chk_u (.*);

//--- verification/sps_status_regs_bench.sv
// Self-checking bench of the serial port status register block.
`timescale 1ns/10ps
`include "sps_defines.svh"

`define SPS_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %0t: got %h want %h", $time, g, e); end end

module sps_status_regs_bench;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [6:0]  be;
    logic [6:0]  pe;
    logic [15:0] st;
  } sps_row_t;
  sps_row_t rows [4] = '{'{4'h5, 7'h5E, 7'h00, 16'h00F1}, '{4'h0, 7'h08, 7'h66, 16'h9220},
                         '{4'hE, 7'h7E, 7'h74, 16'h1313}, '{4'h1, 7'h60, 7'h0C, 16'h2012}};

  logic                   aclk = '0, aresetn = '0;
  logic [5:0]             awaddr = '0, araddr = '0;
  logic [31:0]            wdata = '0, rdata, rdata_q;
  logic                   awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic                   hs_aw = '0, hs_w = '0, hs_b = '0, hs_ar = '0, hs_r = '0;
  logic [1:0]             bresp, rresp, bresp_q, rresp_q;
  logic                   fire_b = '0, fire_p = '0;
  sps_pkg::sps_port_evt_t want_b = '0, want_p = '0, bi_evt, pp_evt;
  sps_pkg::sps_mode_t     bi_mode, pp_mode;
  int                     error_cnt = 0, tests_run = 0;

  initial forever #5 aclk = ~aclk;

  sps_serial_peer peer_b (.aclk(aclk), .fire(fire_b), .want(want_b), .evt(bi_evt));
  sps_serial_peer peer_p (.aclk(aclk), .fire(fire_p), .want(want_p), .evt(pp_evt));

  sps_status_regs #(.AW(6)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .bi_evt(bi_evt), .pp_evt(pp_evt),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bi_mode(bi_mode), .pp_mode(pp_mode));

  // ==========================================================================
  // Bus tasks
  // Handshakes are captured at the falling edge, where they already hold what the next
  // rising edge samples, so the tasks never race the design's own updates.
  always @(negedge aclk) begin
    hs_aw   <= awvalid && awready;
    hs_w    <= wvalid && wready;
    hs_b    <= bvalid && bready;
    hs_ar   <= arvalid && arready;
    hs_r    <= rvalid && rready;
    bresp_q <= bresp;
    rresp_q <= rresp;
    rdata_q <= rdata;
  end

  task automatic conclude();
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic hang();
    $display("unexpected %0t: no answer", $time);
    error_cnt++;
    conclude();
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (hs_aw) awvalid <= 1'h0;
      if (hs_w) wvalid <= 1'h0;
      n++;
    end while (!hs_b && n < 50);
    bready <= 1'h0;
    if (!hs_b) hang();
    else `SPS_CHK(bresp_q, er)
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (hs_ar) arvalid <= 1'h0;
      n++;
    end while (!hs_r && n < 50);
    rready <= 1'h0;
    if (!hs_r) hang();
    else `SPS_CHK({rresp_q, rdata_q}, {er, ed})
  endtask

  task automatic pulse(input logic [6:0] b, input logic [6:0] p, input logic fb, input logic fp);
    @(posedge aclk);
    want_b <= b;
    want_p <= p;
    fire_b <= fb;
    fire_p <= fp;
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `SPS_CHK({bi_mode, pp_mode}, 4'h0)
    rd(6'h00, 32'h0, `SPS_RESP_OKAY);
    rd(6'h20, 32'h0, `SPS_RESP_OKAY);
    rd(6'h24, 32'h0, `SPS_RESP_OKAY);
    rd(6'h28, 32'h0, `SPS_RESP_OKAY);
    foreach (rows[i]) begin
      wr(6'h00, {28'h0, rows[i].ctrl}, `SPS_RESP_OKAY);
      wr(6'h04, 32'hFF, `SPS_RESP_OKAY);
      pulse(rows[i].be, rows[i].pe, 1'h1, 1'h1);
      pulse(7'h00, 7'h00, 1'h0, 1'h0);
      rd(6'h20, {16'h0, rows[i].st}, `SPS_RESP_OKAY);
    end
    // Both ports in plain mode; the built-in counter is run to its last value.
    wr(6'h00, 32'h5, `SPS_RESP_OKAY);
    wr(6'h04, 32'hFF, `SPS_RESP_OKAY);
    for (int i = 0; i < 9999; i++) pulse(7'h01, 7'h01, 1'h1, i < 12);
    pulse(7'h00, 7'h00, 1'h0, 1'h0);
    rd(6'h24, 32'h9999, `SPS_RESP_OKAY);
    rd(6'h28, 32'h0012, `SPS_RESP_OKAY);
    pulse(7'h01, 7'h00, 1'h1, 1'h0);
    pulse(7'h00, 7'h00, 1'h0, 1'h0);
    rd(6'h24, 32'h0000, `SPS_RESP_OKAY);
    wr(6'h00, 32'h1, `SPS_RESP_OKAY);
    rd(6'h28, 32'h0, `SPS_RESP_OKAY);
    wr(6'h00, 32'h5, `SPS_RESP_OKAY);
    rd(6'h28, 32'h0012, `SPS_RESP_OKAY);
    // An event in the cycle of its clear wins: the flag stays and the count restarts at one.
    fork
      begin
        pulse(7'h61, 7'h00, 1'h1, 1'h0);
        pulse(7'h00, 7'h00, 1'h0, 1'h0);
      end
      wr(6'h04, 32'h9, `SPS_RESP_OKAY);
    join
    rd(6'h20, 32'h0012, `SPS_RESP_OKAY);
    rd(6'h24, 32'h0001, `SPS_RESP_OKAY);
    wr(6'h20, 32'hFFFF, `SPS_RESP_SLVERR);
    wr(6'h30, 32'h0, `SPS_RESP_DECERR);
    rd(6'h3C, 32'h0, `SPS_RESP_DECERR);
    rd(6'h04, 32'h0, `SPS_RESP_OKAY);
    // A reset in mid-run drops the modes, the flags and the counts.
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    `SPS_CHK({bi_mode, pp_mode}, 4'h0)
    rd(6'h20, 32'h0, `SPS_RESP_OKAY);
    wr(6'h00, 32'h5, `SPS_RESP_OKAY);
    rd(6'h24, 32'h0, `SPS_RESP_OKAY);
    rd(6'h28, 32'h0, `SPS_RESP_OKAY);
    conclude();
  end
endmodule // sps_status_regs_bench
